/* pkg/sync_dev_pkg.sv */
// Package for the sync word and deviation configuration bank
`default_nettype none
package sync_dev_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SYNC_CFG = 8'h00;
  localparam logic [7:0] ADDR_DEV_M = 8'h04;
  localparam logic [7:0] ADDR_DEV_E = 8'h08;
  localparam logic [7:0] ADDR_PATTERN = 8'h0C;
  localparam logic [7:0] ADDR_SOFT_THR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DEV_WORD = 8'h18;
  // Reset values
  localparam logic [2:0] RST_SYNC_MODE = 3'h5;
  localparam logic [1:0] RST_ERR_CHECK = 2'h3;
  localparam logic [7:0] RST_DEV_M = 8'h06;
  localparam logic [2:0] RST_DEV_E = 3'h3;
  localparam logic [31:0] RST_PATTERN = 32'h930B51DE;
  localparam logic [4:0] RST_SOFT_THR = 5'h0A;
  // Sync length selector codes
  localparam logic [2:0] SM_NONE = 3'h0;
  localparam logic [2:0] SM_11 = 3'h1;
  localparam logic [2:0] SM_16 = 3'h2;
  localparam logic [2:0] SM_18 = 3'h3;
  localparam logic [2:0] SM_24 = 3'h4;
  localparam logic [2:0] SM_32 = 3'h5;
  localparam logic [2:0] SM_16H = 3'h6;
  localparam logic [2:0] SM_DUAL = 3'h7;
  // Bit error check codes
  localparam logic [1:0] EC_ZERO = 2'h0;
  localparam logic [1:0] EC_ONE = 2'h1;
  localparam logic [1:0] EC_OFF = 2'h3;
  // Deviation scaling: word = (256+m) << e for e>0, m << 1 for e=0; Hz = word * fxosc / 2^24
  localparam logic [8:0] DEV_OFFSET = 9'h100;
  localparam int DEV_SCALE_LOG2 = 24;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] pattern;
    logic dual;
    logic [31:0] pattern_b;
    logic [31:0] mask_b;
  } match_cfg_s;
endpackage
`default_nettype wire

/* verilog/sync_word_deviation_config.sv */
// Sync word selection, bit error qualifier and deviation derivation with AXI4-Lite registers
//
// How it works
// - Selector zero disables sync search and every received sample is passed on from receive start.
// - Selectors 1..6 take 11, 16, 18, 24, 32 low-order bits or only the upper two bytes as the pattern.
// - Selector 7 searches both 16-bit halves on receive and transmits only the lower half.
// - The bit error check field resets to 3, which disables it; other values replace the pattern match with a last-byte error condition.
// - Check 0 wants no errors, 1 fewer than two errors, in the last sync byte; 2 is reserved.
// - With a nonzero exponent the deviation word is (256 + mantissa) shifted by the exponent.
// - With a zero exponent the deviation word is the mantissa alone at twice the base step.
// - A candidate is accepted only if its soft error metric is below half the soft threshold.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sync_word_deviation_config (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_window_i,
  input wire logic [31:0] rx_shift_i,
  input wire logic candidate_i,
  input wire logic [4:0] soft_metric_i,
  input wire logic rx_sample_i,
  input wire logic rx_sample_valid_i,
  output logic sync_found_o,
  output logic pass_all_o,
  output logic rx_data_o,
  output logic rx_data_valid_o,
  output logic [31:0] tx_pattern_o,
  output logic [5:0] tx_sync_bits_o,
  output logic [15:0] dev_word_o
);
  logic [2:0] sync_mode;
  logic [1:0] err_check;
  logic [7:0] dev_m;
  logic [2:0] dev_e;
  logic [31:0] pattern;
  logic [4:0] soft_thr;
  logic [7:0] found_count;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  sync_dev_pkg::match_cfg_s cfg;
  logic hit_a, hit_b, hit;
  logic [7:0] last_byte_xor;
  logic [3:0] last_byte_err;
  logic err_ok, soft_ok, accept;
  logic [15:0] next_dev_word;
  logic [31:0] rd_word;
  logic rd_ok;

  // Write address and data may arrive in either order; each is held until both are present
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sync_dev_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == sync_dev_pkg::ADDR_SYNC_CFG || aw_addr == sync_dev_pkg::ADDR_DEV_M ||
                        aw_addr == sync_dev_pkg::ADDR_DEV_E || aw_addr == sync_dev_pkg::ADDR_PATTERN ||
                        aw_addr == sync_dev_pkg::ADDR_SOFT_THR || aw_addr == sync_dev_pkg::ADDR_STATUS ||
                        aw_addr == sync_dev_pkg::ADDR_DEV_WORD) ? sync_dev_pkg::RESP_OKAY : sync_dev_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; upper bits of the sync config register are read only zero
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_mode <= sync_dev_pkg::RST_SYNC_MODE;
      err_check <= sync_dev_pkg::RST_ERR_CHECK;
      dev_m <= sync_dev_pkg::RST_DEV_M;
      dev_e <= sync_dev_pkg::RST_DEV_E;
      pattern <= sync_dev_pkg::RST_PATTERN;
      soft_thr <= sync_dev_pkg::RST_SOFT_THR;
    end else if (do_write) begin
      if (aw_addr == sync_dev_pkg::ADDR_SYNC_CFG && w_strb[0]) begin
        sync_mode <= w_data[4:2];
        err_check <= w_data[1:0];
      end
      if (aw_addr == sync_dev_pkg::ADDR_DEV_M && w_strb[0]) begin
        dev_m <= w_data[7:0];
      end
      if (aw_addr == sync_dev_pkg::ADDR_DEV_E && w_strb[0]) begin
        dev_e <= w_data[2:0];
      end
      if (aw_addr == sync_dev_pkg::ADDR_SOFT_THR && w_strb[0]) begin
        soft_thr <= w_data[4:0];
      end
      if (aw_addr == sync_dev_pkg::ADDR_PATTERN) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb[i]) begin
            pattern[8*i +: 8] <= w_data[8*i +: 8];
          end
        end
      end
    end
  end

  // Pattern and mask per selector code
  always_comb begin
    cfg.pattern = pattern;
    cfg.dual = 1'b0;
    cfg.pattern_b = {16'h0, pattern[31:16]};
    cfg.mask_b = 32'h0000FFFF;
    case (sync_mode)
      sync_dev_pkg::SM_11: cfg.mask = 32'h000007FF;
      sync_dev_pkg::SM_16: cfg.mask = 32'h0000FFFF;
      sync_dev_pkg::SM_18: cfg.mask = 32'h0003FFFF;
      sync_dev_pkg::SM_24: cfg.mask = 32'h00FFFFFF;
      sync_dev_pkg::SM_32: cfg.mask = 32'hFFFFFFFF;
      sync_dev_pkg::SM_16H: begin
        cfg.pattern = {16'h0, pattern[31:16]};
        cfg.mask = 32'h0000FFFF;
      end
      sync_dev_pkg::SM_DUAL: begin
        cfg.mask = 32'h0000FFFF;
        cfg.dual = 1'b1;
      end
      default: cfg.mask = 32'h0;
    endcase
  end

  assign hit_a = ((rx_shift_i ^ cfg.pattern) & cfg.mask) == 32'h0;
  assign hit_b = cfg.dual && (((rx_shift_i ^ cfg.pattern_b) & cfg.mask_b) == 32'h0);
  // Candidate already chosen by the demodulator; mismatches in the last byte are counted here
  assign hit = (err_check == sync_dev_pkg::EC_OFF) ? (hit_a || hit_b) : 1'b1;
  assign last_byte_xor = hit_b && !hit_a ? rx_shift_i[7:0] ^ cfg.pattern_b[7:0] : rx_shift_i[7:0] ^ cfg.pattern[7:0];
  assign last_byte_err = 4'($countones(last_byte_xor));

  always_comb begin
    case (err_check)
      sync_dev_pkg::EC_ZERO: err_ok = last_byte_err == 4'h0;
      sync_dev_pkg::EC_ONE: err_ok = last_byte_err < 4'h2;
      sync_dev_pkg::EC_OFF: err_ok = 1'b1;
      default: err_ok = 1'b0;
    endcase
  end

  // Metric below thr/2, kept exact by doubling the metric
  assign soft_ok = {1'b0, soft_metric_i, 1'b0} < {2'b00, soft_thr};
  assign accept = candidate_i && rx_window_i && sync_mode != sync_dev_pkg::SM_NONE && hit && err_ok && soft_ok;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_found_o <= 1'b0;
      found_count <= 8'h00;
    end else begin
      sync_found_o <= accept;
      if (accept) begin
        found_count <= found_count + 8'h01;
      end
    end
  end

  // Pass-through while no sync is used
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pass_all_o <= 1'b0;
      rx_data_o <= 1'b0;
      rx_data_valid_o <= 1'b0;
    end else begin
      pass_all_o <= rx_window_i && sync_mode == sync_dev_pkg::SM_NONE;
      rx_data_o <= rx_sample_i;
      rx_data_valid_o <= rx_window_i && sync_mode == sync_dev_pkg::SM_NONE && rx_sample_valid_i;
    end
  end

  // Transmit side sends the masked pattern; dual mode sends only the lower half
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_pattern_o <= 32'h0;
      tx_sync_bits_o <= 6'h00;
    end else begin
      tx_pattern_o <= cfg.pattern & cfg.mask;
      case (sync_mode)
        sync_dev_pkg::SM_11: tx_sync_bits_o <= 6'h0B;
        sync_dev_pkg::SM_16, sync_dev_pkg::SM_16H, sync_dev_pkg::SM_DUAL: tx_sync_bits_o <= 6'h10;
        sync_dev_pkg::SM_18: tx_sync_bits_o <= 6'h12;
        sync_dev_pkg::SM_24: tx_sync_bits_o <= 6'h18;
        sync_dev_pkg::SM_32: tx_sync_bits_o <= 6'h20;
        default: tx_sync_bits_o <= 6'h00;
      endcase
    end
  end

  // Deviation in steps of fxosc/2^24; the zero exponent case is mantissa * 2 steps
  always_comb begin
    if (dev_e != 3'h0) begin
      next_dev_word = 16'({7'h00, sync_dev_pkg::DEV_OFFSET + {1'b0, dev_m}} << dev_e);
    end else begin
      next_dev_word = {7'h00, dev_m, 1'b0};
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_word_o <= 16'h0;
    end else begin
      dev_word_o <= next_dev_word;
    end
  end

  // Read channel, one read answered at a time
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      sync_dev_pkg::ADDR_SYNC_CFG: rd_word = {27'h0, sync_mode, err_check};
      sync_dev_pkg::ADDR_DEV_M: rd_word = {24'h0, dev_m};
      sync_dev_pkg::ADDR_DEV_E: rd_word = {29'h0, dev_e};
      sync_dev_pkg::ADDR_PATTERN: rd_word = pattern;
      sync_dev_pkg::ADDR_SOFT_THR: rd_word = {27'h0, soft_thr};
      sync_dev_pkg::ADDR_STATUS: rd_word = {22'h0, pass_all_o, sync_found_o, found_count};
      sync_dev_pkg::ADDR_DEV_WORD: rd_word = {16'h0, dev_word_o};
      default: begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sync_dev_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? sync_dev_pkg::RESP_OKAY : sync_dev_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/swdc_props.sv */
// Concurrent property checker for the sync word and deviation bank
`timescale 1ns/1ps
`default_nettype none
module swdc_props (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_window_i,
  input wire logic candidate_i,
  input wire logic rx_sample_i,
  input wire logic rx_sample_valid_i,
  input wire logic sync_found_o,
  input wire logic pass_all_o,
  input wire logic rx_data_o,
  input wire logic rx_data_valid_o,
  input wire logic [31:0] tx_pattern_o,
  input wire logic [5:0] tx_sync_bits_o,
  input wire logic [15:0] dev_word_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  found_cause_a: assert property (sync_found_o |-> $past(candidate_i && rx_window_i)) else $error("stray sync");
  found_pass_a: assert property (sync_found_o |-> !pass_all_o) else $error("sync in pass mode");
  pass_window_a: assert property (pass_all_o |-> $past(rx_window_i)) else $error("pass outside window");
  copy_data_a: assert property (rx_data_valid_o |-> $past(rx_sample_valid_i) && rx_data_o == $past(rx_sample_i))
    else $error("bad sample copy");
  copy_gate_a: assert property (rx_data_valid_o |-> pass_all_o) else $error("copy not in pass mode");
  tx_len_a: assert property (tx_sync_bits_o inside {6'h00, 6'h0B, 6'h10, 6'h12, 6'h18, 6'h20})
    else $error("bad sync length");
  tx_mask_a: assert property (tx_sync_bits_o < 6'h20 |-> (tx_pattern_o >> tx_sync_bits_o) == 32'h0)
    else $error("pattern not masked");
  dev_step_a: assert property (dev_word_o[0] == 1'b0) else $error("odd deviation word");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (sync_found_o);
  cover property (rx_data_valid_o);
  cover property (pass_all_o ##1 !pass_all_o);
endmodule
bind sync_word_deviation_config swdc_props p_u (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .rx_window_i(rx_window_i), .candidate_i(candidate_i), .rx_sample_i(rx_sample_i),
  .rx_sample_valid_i(rx_sample_valid_i), .sync_found_o(sync_found_o), .pass_all_o(pass_all_o),
  .rx_data_o(rx_data_o), .rx_data_valid_o(rx_data_valid_o), .tx_pattern_o(tx_pattern_o),
  .tx_sync_bits_o(tx_sync_bits_o), .dev_word_o(dev_word_o)
);
`default_nettype wire

/* bench/sync_word_deviation_config_tb_top.sv */
// Register-level testbench for the sync word and deviation bank
`timescale 1ns/1ps
`default_nettype none
module sync_word_deviation_config_tb_top;
  logic mclk_i, rstn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_window_i, candidate_i;
  logic rx_sample_i, rx_sample_valid_i, sync_found_o, pass_all_o, rx_data_o, rx_data_valid_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx_shift_i, tx_pattern_o, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic [4:0] soft_metric_i;
  logic [3:0] s_axi_wstrb;
  logic [5:0] tx_sync_bits_o;
  logic [15:0] dev_word_o;
  int err_count = 0;
  int checked = 0;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [31:0] rv [6] = '{32'h17, 32'h06, 32'h03, 32'h930B51DE, 32'h0A, 32'h830};
  logic [31:0] bt [8] = '{32'h0, 32'h0B, 32'h10, 32'h12, 32'h18, 32'h20, 32'h10, 32'h10};
  logic [31:0] pt [8] = '{32'h0, 32'h1DE, 32'h51DE, 32'h351DE, 32'hB51DE, 32'h930B51DE, 32'h930B, 32'h51DE};
  sync_word_deviation_config dut_u (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_window_i(rx_window_i), .rx_shift_i(rx_shift_i), .candidate_i(candidate_i),
    .soft_metric_i(soft_metric_i), .rx_sample_i(rx_sample_i), .rx_sample_valid_i(rx_sample_valid_i),
    .sync_found_o(sync_found_o), .pass_all_o(pass_all_o), .rx_data_o(rx_data_o),
    .rx_data_valid_o(rx_data_valid_o), .tx_pattern_o(tx_pattern_o), .tx_sync_bits_o(tx_sync_bits_o),
    .dev_word_o(dev_word_o)
  );
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hF,
                    input logic [1:0] er = 2'h0);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  task automatic cand(input logic [31:0] sh, input logic [4:0] m, input logic e);
    @(posedge mclk_i);
    rx_shift_i <= sh;
    soft_metric_i <= m;
    candidate_i <= 1'b1;
    @(posedge mclk_i);
    candidate_i <= 1'b0;
    #1 chk({31'h0, sync_found_o}, {31'h0, e});
  endtask
  task automatic complete_run;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Generous ceiling; the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    complete_run;
  end
  initial begin
    {rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {candidate_i, rx_sample_i, rx_sample_valid_i, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, rx_shift_i, soft_metric_i, s_axi_wstrb} = '0;
    rx_window_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(ra[i], rv[i], 2'h0);
    rchk(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'hFFFFFFFF, 4'hF, 2'h2);
    $display("test reset done");
    wr(sync_dev_pkg::ADDR_DEV_M, 32'h10);
    wr(sync_dev_pkg::ADDR_DEV_E, 32'h0);
    chk({16'h0, dev_word_o}, 32'h20);
    wr(sync_dev_pkg::ADDR_DEV_M, 32'hFF);
    wr(sync_dev_pkg::ADDR_DEV_E, 32'h7);
    chk({16'h0, dev_word_o}, 32'hFF80);
    $display("test deviation done");
    for (int s = 1; s < 8; s++) begin
      wr(sync_dev_pkg::ADDR_SYNC_CFG, {27'h0, s[2:0], 2'h3});
      chk({26'h0, tx_sync_bits_o}, bt[s]);
      chk(tx_pattern_o, pt[s]);
    end
    $display("test length done");
    cand(32'h0000930B, 5'h0, 1'b1);
    cand(32'h000051DE, 5'h0, 1'b1);
    wr(sync_dev_pkg::ADDR_SYNC_CFG, 32'h17);
    cand(32'h930B51DE, 5'h4, 1'b1);
    cand(32'h930B51DE, 5'h5, 1'b0);
    cand(32'h930B51DF, 5'h0, 1'b0);
    wr(sync_dev_pkg::ADDR_SYNC_CFG, 32'h14);
    cand(32'h930B51DE, 5'h0, 1'b1);
    cand(32'h930B51DF, 5'h0, 1'b0);
    wr(sync_dev_pkg::ADDR_SYNC_CFG, 32'h15);
    cand(32'h930B51DF, 5'h0, 1'b1);
    cand(32'h930B51DD, 5'h0, 1'b0);
    wr(sync_dev_pkg::ADDR_SYNC_CFG, 32'h16);
    cand(32'h930B51DE, 5'h0, 1'b0);
    $display("test sync done");
    wr(sync_dev_pkg::ADDR_SYNC_CFG, 32'h03);
    cand(32'h930B51DE, 5'h0, 1'b0);
    rx_sample_valid_i <= 1'b1;
    rx_sample_i <= 1'b1;
    @(posedge mclk_i);
    rx_sample_i <= 1'b0;
    #1 chk({30'h0, pass_all_o, rx_data_o}, 32'h3);
    @(posedge mclk_i);
    #1 chk({30'h0, rx_data_valid_o, rx_data_o}, 32'h2);
    rchk(sync_dev_pkg::ADDR_STATUS, 32'h205, 2'h0);
    rx_window_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk({30'h0, pass_all_o, rx_data_valid_o}, 32'h0);
    wr(sync_dev_pkg::ADDR_SYNC_CFG, 32'h17);
    cand(32'h930B51DE, 5'h0, 1'b0);
    rx_window_i <= 1'b1;
    @(posedge mclk_i);
    #1 chk({30'h0, pass_all_o, rx_data_valid_o}, 32'h0);
    $display("test pass done");
    wr(sync_dev_pkg::ADDR_PATTERN, 32'hA5A5A5A5, 4'h2);
    rchk(sync_dev_pkg::ADDR_PATTERN, 32'h930BA5DE, 2'h0);
    chk(tx_pattern_o, 32'h930BA5DE);
    $display("test strobe done");
    complete_run;
  end
endmodule
`default_nettype wire
